// ==== dv/mas_motion_model.sv ====
// Purpose: Motion model of the four axes behind the start logic
// Assumes: Start pulses one cycle long, dur_in held while axes run
// Notes:   Each run lasts dur_in cycles, dur_in at least 4
`timescale 1ns/10ps
module mas_motion_model (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Control
  input  wire logic [3:0]  start_in,
  input  wire logic [3:0]  dur_in,
  // Axis activity
  output logic      [3:0]  busy_out,
  output logic      [15:0] ramp_out
);
  logic [3:0] cnt_reg [4];

  // ---------------------------------------------------------------
  // Run counters
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    for (int a = 0; a < 4; a++) begin
      if (rst_in) begin
        cnt_reg[a] <= 4'h0;
      end else if (start_in[a]) begin
        cnt_reg[a] <= 4'h1;
      end else if (cnt_reg[a] == dur_in) begin
        cnt_reg[a] <= 4'h0;
      end else if (cnt_reg[a] != 4'h0) begin
        cnt_reg[a] <= cnt_reg[a] + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Busy level and ramp milestones
  // ---------------------------------------------------------------
  always_comb begin
    for (int a = 0; a < 4; a++) begin
      busy_out[a]     = cnt_reg[a] != 4'h0;
      ramp_out[4*a]   = cnt_reg[a] == 4'h1;
      ramp_out[4*a+1] = cnt_reg[a] == 4'h2;
      ramp_out[4*a+2] = cnt_reg[a] == dur_in - 4'h1;
      ramp_out[4*a+3] = cnt_reg[a] == dur_in;
    end
  end
endmodule

// ==== dv/mas_top_tb.sv ====
// Purpose: Self-checking bench of the multi-axis start logic
// Assumes: Motion model answers start pulses
// Notes:   Random values from an xorshift seeded with 4
`timescale 1ns/10ps
module mas_top_tb;
  logic        clk_in, rst_in, wr_in, rd_in, int_n_out;
  logic [7:0]  addr_in;
  logic [31:0] wdata_in, rdata_out, seed;
  logic [3:0]  start_cmd_in, busy_in, start_out, sync_out, dur;
  logic [19:0] cmp_hit_in;
  logic [15:0] ramp_evt_in;
  int          mismatches, check_count, ax;
  logic [3:0]  ts [6] = '{4'h1, 4'h2, 4'h4, 4'hB, 4'h3, 4'h8};
  logic [3:0]  tr [6] = '{4'h1, 4'h2, 4'h4, 4'h3, 4'h1, 4'h0};
  int          tq [6] = '{3, 0, 0, 3, 0, 0};

  mas_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .start_cmd_in(start_cmd_in),
    .busy_in(busy_in), .cmp_hit_in(cmp_hit_in),
    .ramp_evt_in(ramp_evt_in), .start_out(start_out),
    .sync_out(sync_out), .int_n_out(int_n_out));
  mas_motion_model i_axes (.clk_in(clk_in), .rst_in(rst_in),
    .start_in(start_out), .dur_in(dur), .busy_out(busy_in),
    .ramp_out(ramp_evt_in));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] ra(input int a, input logic [7:0] o);
    return {1'b0, a[1:0], 5'h00} | o;
  endfunction
  // Event bit behind a sync timing code, zero when none
  function automatic logic [31:0] evt_bit(input logic [3:0] c);
    if (c >= 4'h1 && c <= 4'h5) return 32'h0000_0080 << c;
    if (c >= 4'h8 && c <= 4'hB) return 32'h0000_0001 << (c - 4'h4);
    return 32'h0000_0000;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_in);
    addr_in  <= ad;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    @(posedge clk_in);
    addr_in <= ad;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, exp);
  endtask
  task automatic pulse(input logic [3:0] c, input logic [19:0] h);
    @(posedge clk_in);
    start_cmd_in <= c;
    cmp_hit_in   <= h;
    @(posedge clk_in);
    start_cmd_in <= 4'h0;
    cmp_hit_in   <= 20'h0_0000;
    #1;
  endtask
  task automatic wait_start(input int a, input int lim);
    int n;
    n = 0;
    while (start_out[a] !== 1'b1 && n < lim) begin
      tick();
      n++;
    end
    if (n >= lim) begin
      mismatches++;
      $display("[FAIL] %0t no start on axis %0d", $time, a);
      print_verdict();
    end
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic sync_case(input int s);
    int w, n;
    w = (s + 1) % 4;
    n = int'(rnd() % 32'd5) + 1;
    wr(ra(w, mas_pkg::OFS_MODE), 32'h0008_0000);
    wr(ra(w, mas_pkg::OFS_ENV5), s << 20);
    wr(ra(s, mas_pkg::OFS_ENV5), n << 16);
    pulse(4'h1 << w, 20'h0_0000);
    rd(ra(w, mas_pkg::OFS_STAT), 32'h0000_0003);
    pulse(4'h0, 20'h0_0001 << (s * 5 + n % 5));
    chk(sync_out, 32'h0000_0000);
    tick();
    chk(start_out, 32'h0000_0000);
    pulse(4'h0, 20'h0_0001 << (s * 5 + n - 1));
    chk(sync_out, 4'h1 << s);
    tick();
    chk(start_out, 4'h1 << w);
    tick();
    chk({sync_out, start_out}, 32'h0000_0000);
    wr(ra(w, mas_pkg::OFS_MODE), 32'h0000_0000);
  endtask

  task automatic stop_case(input logic [3:0] sel, input logic [3:0] run,
                           input logic ext, input int quiet);
    // Let runs of earlier cases end before the wait begins
    repeat (12) tick();
    wr(ra(3, mas_pkg::OFS_ENV2), {2'b00, ext, 29'h0000_0000});
    wr(ra(3, mas_pkg::OFS_MODE), {8'h00, sel, 20'hC_0000});
    pulse(4'h8, 20'h0_0000);
    repeat (quiet) begin
      tick();
      chk(start_out, 32'h0000_0000);
    end
    if (quiet > 0) rd(ra(3, mas_pkg::OFS_STAT), 32'h0000_0004);
    for (int a = 0; a < 3; a++) begin
      if (run[a]) pulse(4'h1 << a, 20'h0_0000);
    end
    wait_start(3, 80);
    chk(busy_in[2:0], 32'h0000_0000);
    repeat (20) tick();
  endtask

  task automatic ev_case(input logic [3:0] code);
    logic [31:0] en;
    int          np;
    en = (rnd() & 32'h0000_1FF0) | (code[0] ? evt_bit(code) : 32'h0000_0000);
    np = 0;
    @(posedge clk_in);
    dur <= 4'h4 + 4'(rnd() % 32'd12);
    wr(ra(0, mas_pkg::OFS_ENV5), {12'h000, code, 16'h0000});
    wr(ra(0, mas_pkg::OFS_IRQ), en);
    pulse(4'h1, 20'h0_001F);
    repeat (24) begin
      if (sync_out[0] === 1'b1) begin
        np++;
        if ((en & evt_bit(code)) != 0) chk(int_n_out, 32'h0);
      end
      tick();
    end
    chk(np, evt_bit(code) != 0);
    chk(int_n_out, en == 0);
    rd(ra(0, mas_pkg::OFS_CAUSE), en);
    wr(ra(0, mas_pkg::OFS_CAUSE), 32'h0000_1FF0);
    tick();
    chk(int_n_out, 32'h0000_0001);
  endtask

  // ---------------------------------------------------------------
  // Clock and main sequence
  // ---------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  initial begin
    {wr_in, rd_in, addr_in, wdata_in} = '0;
    start_cmd_in = 4'h0;
    cmp_hit_in   = 20'h0_0000;
    dur          = 4'h8;
    seed         = 32'h0000_0004;
    mismatches   = 0;
    check_count  = 0;
    rst_in       = 1'b1;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    tick();
    chk(int_n_out, 32'h0000_0001);
    ax = int'(rnd() % 32'd4);
    for (int o = 0; o < 24; o += 4) rd(ra(ax, 8'(o)), 32'h0000_0000);
    rd(ra(ax, 8'h18), 32'h0000_0000);
    wr(ra(ax, mas_pkg::OFS_STAT), rnd());
    rd(ra(ax, mas_pkg::OFS_STAT), 32'h0000_0000);
    for (int s = 0; s < 4; s++) sync_case(s);
    for (int i = 0; i < 6; i++) begin
      stop_case(ts[i], tr[i], i == 5, tq[i]);
    end
    for (int c = 0; c < 16; c++) ev_case(4'(c));
    print_verdict();
  end
endmodule

// ==== logic/mas_axis.sv ====
// Purpose: Start-wait sequencer and sync pulse source of one axis
// Assumes: All inputs come from logic on clk_in
// Notes:   Start and sync outputs are one-cycle pulses from flops
`timescale 1ns/10ps
module mas_axis #(
  parameter int AXES    = 4,
  parameter int AXIS_ID = 0
) (
  // Clock and reset
  input  wire logic            clk_in,
  input  wire logic            rst_in,
  // Configuration
  input  wire logic [31:0]     mode_in,
  input  wire logic [31:0]     env2_in,
  input  wire logic [31:0]     env5_in,
  // Axis activity
  input  wire logic            start_cmd_in,
  input  wire logic [AXES-1:0] busy_in,
  input  wire logic [AXES-1:0] sync_bus_in,
  input  wire logic [4:0]      cmp_in,
  input  wire logic [3:0]      ramp_in,
  // Results
  output logic                 start_out,
  output logic                 sync_out,
  output logic [3:0]           cond_out
);

  typedef struct packed {
    mas_pkg::mas_wait_type st;
    logic                  start;
    logic                  sync;
    logic                  seen_stop;
    logic [AXES-1:0]       busy_d;
  } mas_axis_state_type;

  mas_axis_state_type s_reg, s_next;
  logic [AXES-1:0]    sel;
  logic [AXES-1:0]    fell;
  logic               busy_sel;
  logic               go;
  logic [1:0]         src;
  logic [3:0]         code;

  function automatic logic timing_hit(input logic [3:0] c,
                                      input logic [4:0] cmp,
                                      input logic [3:0] ramp);
    logic hit;
    hit = 1'b0;
    if (c >= mas_pkg::TIM_CMP_FIRST && c <= mas_pkg::TIM_CMP_LAST) begin
      hit = cmp[3'(c - mas_pkg::TIM_CMP_FIRST)];
    end else if (c >= mas_pkg::TIM_RAMP_FIRST &&
                 c <= mas_pkg::TIM_RAMP_LAST) begin
      hit = ramp[2'(c - mas_pkg::TIM_RAMP_FIRST)];
    end
    return hit;
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next        = s_reg;
    s_next.start  = 1'b0;
    s_next.busy_d = busy_in;
    code          = env5_in[mas_pkg::SYO_LSB+:4];
    s_next.sync   = timing_hit(code, cmp_in, ramp_in); // [R08] [R09] [R10]
    sel           = mode_in[mas_pkg::AXSEL_LSB+:4]; // [R02]
    if (!env2_in[mas_pkg::EXT_BIT]) begin
      sel[AXIS_ID] = 1'b0; // [R04] [R05]
    end
    fell     = s_reg.busy_d & ~busy_in & sel; // [R05]
    busy_sel = |(busy_in & sel); // [R03] [R07]
    src      = env5_in[mas_pkg::SYI_LSB+:2];
    go       = 1'b0;
    case (s_reg.st)
      mas_pkg::ST_IDLE: begin
        if (start_cmd_in) begin
          if (mode_in[mas_pkg::METHOD_LSB+:2] == mas_pkg::METHOD_SYNC) begin
            s_next.st = mas_pkg::ST_WAIT_SYNC; // [R01]
          end else if (mode_in[mas_pkg::METHOD_LSB+:2] ==
                       mas_pkg::METHOD_STOP) begin
            s_next.st        = mas_pkg::ST_WAIT_STOP; // [R01]
            s_next.seen_stop = 1'b0;
          end else begin
            s_next.start = 1'b1;
          end
        end
      end
      mas_pkg::ST_WAIT_SYNC: begin
        go = sync_bus_in[src]; // [R11] [R19]
      end
      mas_pkg::ST_WAIT_STOP: begin
        s_next.seen_stop = s_reg.seen_stop | (|fell);
        if (env2_in[mas_pkg::EXT_BIT]) begin
          go = !busy_sel && (|sel); // [R06] [R07]
        end else begin
          go = !busy_sel && s_next.seen_stop; // [R03] [R05] [R07]
        end
      end
      default: begin
        s_next.st = mas_pkg::ST_IDLE;
      end
    endcase
    if (go) begin
      s_next.start = 1'b1; // [R19]
      s_next.st    = mas_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg <= '{st: mas_pkg::ST_IDLE, start: 1'b0, sync: 1'b0,
                 seen_stop: 1'b0, busy_d: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign start_out = s_reg.start;
  assign sync_out  = s_reg.sync;
  always_comb begin
    case (s_reg.st)
      mas_pkg::ST_WAIT_SYNC: cond_out = mas_pkg::COND_WAIT_SYNC; // [R12]
      mas_pkg::ST_WAIT_STOP: cond_out = mas_pkg::COND_WAIT_STOP; // [R12]
      default:               cond_out = mas_pkg::COND_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_sync_seen;
    s_reg.st == mas_pkg::ST_WAIT_SYNC && sync_bus_in[src];
  endsequence
  sequence s_started;
    start_out && s_reg.st == mas_pkg::ST_IDLE;
  endsequence

  property p_sync_release;
    s_sync_seen |=> s_started;
  endproperty
  a_sync_release: assert property (p_sync_release) // [R11] [R19]
    else $error("waiting axis did not start after sync pulse");

  property p_enter_sync;
    s_reg.st == mas_pkg::ST_IDLE && start_cmd_in &&
    mode_in[mas_pkg::METHOD_LSB+:2] == mas_pkg::METHOD_SYNC
    |=> s_reg.st == mas_pkg::ST_WAIT_SYNC ##0 !start_out;
  endproperty
  a_enter_sync: assert property (p_enter_sync) // [R01]
    else $error("sync method did not enter sync wait");

  property p_cond_stop;
    s_reg.st == mas_pkg::ST_WAIT_STOP |->
      cond_out == mas_pkg::COND_WAIT_STOP;
  endproperty
  a_cond_stop: assert property (p_cond_stop) // [R12]
    else $error("stop wait status code wrong");

  property p_hold_busy;
    s_reg.st == mas_pkg::ST_WAIT_STOP && busy_sel |=> !start_out;
  endproperty
  a_hold_busy: assert property (p_hold_busy) // [R03]
    else $error("started while a selected axis still runs");

  property p_legacy_edge;
    s_reg.st == mas_pkg::ST_WAIT_STOP && !env2_in[mas_pkg::EXT_BIT] &&
    !s_reg.seen_stop && fell == '0 |=> !start_out;
  endproperty
  a_legacy_edge: assert property (p_legacy_edge) // [R05]
    else $error("legacy start without a stop transition");

  property p_ext_level;
    s_reg.st == mas_pkg::ST_WAIT_STOP && env2_in[mas_pkg::EXT_BIT] &&
    (|sel) && !busy_sel |=> s_started;
  endproperty
  a_ext_level: assert property (p_ext_level) // [R06] [R07]
    else $error("extended start missed with selected axes idle");

  property p_cmp_code;
    code == mas_pkg::TIM_CMP_LAST && cmp_in[4] |=> sync_out;
  endproperty
  a_cmp_code: assert property (p_cmp_code) // [R08]
    else $error("comparator five did not emit sync pulse");

  property p_ramp_code;
    code == mas_pkg::TIM_RAMP_FIRST && ramp_in[0] |=> sync_out;
  endproperty
  a_ramp_code: assert property (p_ramp_code) // [R09]
    else $error("acceleration start did not emit sync pulse");

  property p_timing_off;
    !(code inside {[mas_pkg::TIM_CMP_FIRST:mas_pkg::TIM_CMP_LAST],
                   [mas_pkg::TIM_RAMP_FIRST:mas_pkg::TIM_RAMP_LAST]})
    |=> !sync_out;
  endproperty
  a_timing_off: assert property (p_timing_off) // [R10]
    else $error("sync pulse emitted for an unlisted code");

endmodule

// ==== logic/mas_pkg.sv ====
// Purpose: Shared constants and types of the multi-axis start logic
// Assumes: Four axes, one 40 MHz clock, word-aligned register port
// Notes:   Each offset, field and code is named here once
package mas_pkg;

  // ---------------------------------------------------------------
  // Structure
  // ---------------------------------------------------------------
  localparam int AXES  = 4;
  localparam int CMPS  = 5;
  localparam int RAMPS = 4;
  localparam int EVTS  = 9;

  // ---------------------------------------------------------------
  // Register offsets within one axis window
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_MODE  = 8'h00;
  localparam logic [7:0] OFS_ENV2  = 8'h04;
  localparam logic [7:0] OFS_ENV5  = 8'h08;
  localparam logic [7:0] OFS_IRQ   = 8'h0C;
  localparam logic [7:0] OFS_STAT  = 8'h10;
  localparam logic [7:0] OFS_CAUSE = 8'h14;
  localparam int         AXIS_LSB  = 5;
  localparam int         SPACE_BIT = 7;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int METHOD_LSB = 18;
  localparam int AXSEL_LSB  = 20;
  localparam int EXT_BIT    = 29;
  localparam int SYO_LSB    = 16;
  localparam int SYI_LSB    = 20;
  localparam int COND_LSB   = 0;
  localparam int EVT_LSB    = 4;

  // ---------------------------------------------------------------
  // Codes and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0]  METHOD_SYNC    = 2'h2;
  localparam logic [1:0]  METHOD_STOP    = 2'h3;
  localparam logic [3:0]  COND_IDLE      = 4'h0;
  localparam logic [3:0]  COND_WAIT_SYNC = 4'h3;
  localparam logic [3:0]  COND_WAIT_STOP = 4'h4;
  localparam logic [3:0]  TIM_CMP_FIRST  = 4'h1;
  localparam logic [3:0]  TIM_CMP_LAST   = 4'h5;
  localparam logic [3:0]  TIM_RAMP_FIRST = 4'h8;
  localparam logic [3:0]  TIM_RAMP_LAST  = 4'hB;
  localparam logic [31:0] REG_RESET      = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'h1,
    ST_WAIT_SYNC = 3'h2,
    ST_WAIT_STOP = 3'h4
  } mas_wait_type;

endpackage

// ==== logic/mas_top.sv ====
// Purpose: Four-axis synchronous start, sync pulse and event logic
// Assumes: Event and busy inputs come from logic on clk_in
// Notes:   Plain register port, read data valid one cycle later
//
// Summary of operation
// R01: Method field 10 sync wait, 11 stop wait
// R02: Axis-select bits pick watched axes X..U
// R03: Several selected axes: all must stop
// R04: Bit 29 picks legacy or extended stop mode
// R05: Legacy needs stop transition; own axis excluded
// R06: Extended mode may include own axis
// R07: Never-started selected axes do not block start
// R08: Timing codes 1..5 pulse on comparators 1..5
// R09: Timing codes 8..B pulse on ramp milestones
// R10: Other timing codes keep sync output off
// R11: Sync-input field picks releasing axis pulse
// R12: Status reads 0011 sync wait, 0100 stop wait
// R13: Enable bits 4..7 for ramp milestone events
// R14: Enable bits 8..12 for comparator events
// R15: Enabled event drives interrupt output low
// R16: Cause bits 4..7 report ramp events
// R17: Cause bits 8..12 report comparator events
// R18: Interrupt asserts with same-cycle sync pulse
// R19: One-cycle sync pulse; start next cycle
// R20: Cause and interrupt held until cleared
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module mas_top #(
  parameter int AXES  = mas_pkg::AXES,
  parameter int CMPS  = mas_pkg::CMPS,
  parameter int RAMPS = mas_pkg::RAMPS
) (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  // Register port
  input  wire logic [7:0]           addr_in,
  input  wire logic [31:0]          wdata_in,
  input  wire logic                 wr_in,
  input  wire logic                 rd_in,
  output logic [31:0]               rdata_out,
  // Axis activity
  input  wire logic [AXES-1:0]      start_cmd_in,
  input  wire logic [AXES-1:0]      busy_in,
  input  wire logic [AXES*CMPS-1:0] cmp_hit_in,
  input  wire logic [AXES*RAMPS-1:0] ramp_evt_in,
  // Results
  output logic [AXES-1:0]           start_out,
  output logic [AXES-1:0]           sync_out,
  output logic                      int_n_out
);

  localparam int EVTS = mas_pkg::EVTS;

  // ---------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------
  if (AXES != mas_pkg::AXES || CMPS != mas_pkg::CMPS ||
      RAMPS != mas_pkg::RAMPS) begin : g_bad_size
    $error("mas_top: field layout serves four axes only");
  end

  typedef struct packed {
    logic [AXES-1:0][31:0]     mode;
    logic [AXES-1:0][31:0]     env2;
    logic [AXES-1:0][31:0]     env5;
    logic [AXES-1:0][31:0]     irq;
    logic [AXES-1:0][EVTS-1:0] cause;
    logic [31:0]               rdata;
    logic                      int_n;
  } mas_top_state_type;

  mas_top_state_type         s_reg, s_next;
  logic [AXES-1:0][3:0]      cond;
  logic [AXES-1:0][EVTS-1:0] evt_en;
  logic [EVTS-1:0]           evt;
  logic [EVTS-1:0]           clr;
  logic [1:0]                acc_axis;
  logic [7:0]                reg_ofs;
  logic                      acc_ok;

  // ---------------------------------------------------------------
  // Register file, causes and interrupt
  // ---------------------------------------------------------------
  always_comb begin
    s_next       = s_reg;
    s_next.rdata = mas_pkg::REG_RESET;
    acc_axis     = addr_in[mas_pkg::AXIS_LSB+:2];
    reg_ofs      = {3'h0, addr_in[4:0]};
    acc_ok       = !addr_in[mas_pkg::SPACE_BIT] && addr_in[1:0] == 2'h0;
    evt          = '0;
    clr          = '0;
    evt_en       = '0;
    for (int a = 0; a < AXES; a++) begin
      evt = {cmp_hit_in[a*CMPS+:CMPS], ramp_evt_in[a*RAMPS+:RAMPS]};
      // Ramp events in bits 4..7, comparators in bits 8..12
      evt_en[a] = evt & s_reg.irq[a][mas_pkg::EVT_LSB+:EVTS]; // [R13] [R14]
      clr = '0;
      if (wr_in && acc_ok && acc_axis == 2'(a) &&
          reg_ofs == mas_pkg::OFS_CAUSE) begin
        clr = wdata_in[mas_pkg::EVT_LSB+:EVTS];
      end
      // New event wins over a clear in the same cycle
      s_next.cause[a] = (s_reg.cause[a] & ~clr) |
                        evt_en[a]; // [R16] [R17] [R20]
    end
    if (wr_in && acc_ok) begin
      case (reg_ofs)
        mas_pkg::OFS_MODE: s_next.mode[acc_axis] = wdata_in;
        mas_pkg::OFS_ENV2: s_next.env2[acc_axis] = wdata_in;
        mas_pkg::OFS_ENV5: s_next.env5[acc_axis] = wdata_in;
        mas_pkg::OFS_IRQ:  s_next.irq[acc_axis]  = wdata_in;
        default: ;
      endcase
    end
    // Registered with the sync pulse of the same event
    s_next.int_n = ~|s_next.cause; // [R15] [R18] [R20]
    if (rd_in && acc_ok) begin
      case (reg_ofs)
        mas_pkg::OFS_MODE: s_next.rdata = s_reg.mode[acc_axis];
        mas_pkg::OFS_ENV2: s_next.rdata = s_reg.env2[acc_axis];
        mas_pkg::OFS_ENV5: s_next.rdata = s_reg.env5[acc_axis];
        mas_pkg::OFS_IRQ:  s_next.rdata = s_reg.irq[acc_axis];
        mas_pkg::OFS_STAT: begin
          s_next.rdata = {28'h000_0000, cond[acc_axis]}; // [R12]
        end
        mas_pkg::OFS_CAUSE: begin
          s_next.rdata = {19'h0_0000, s_reg.cause[acc_axis],
                          4'h0}; // [R16] [R17]
        end
        default: s_next.rdata = mas_pkg::REG_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg <= '{mode: '0, env2: '0, env5: '0, irq: '0, cause: '0,
                 rdata: mas_pkg::REG_RESET, int_n: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata_out = s_reg.rdata;
  assign int_n_out = s_reg.int_n;

  // ---------------------------------------------------------------
  // Per-axis start logic
  // ---------------------------------------------------------------
  for (genvar g = 0; g < AXES; g++) begin : g_axis
    mas_axis #(
      .AXES    (AXES),
      .AXIS_ID (g)
    ) u_axis (
      .clk_in       (clk_in),
      .rst_in       (rst_in),
      .mode_in      (s_reg.mode[g]),
      .env2_in      (s_reg.env2[g]),
      .env5_in      (s_reg.env5[g]),
      .start_cmd_in (start_cmd_in[g]),
      .busy_in      (busy_in),
      .sync_bus_in  (sync_out),
      .cmp_in       (cmp_hit_in[g*CMPS+:CMPS]),
      .ramp_in      (ramp_evt_in[g*RAMPS+:RAMPS]),
      .start_out    (start_out[g]),
      .sync_out     (sync_out[g]),
      .cond_out     (cond[g])
    );
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_enabled_event;
    evt_en != '0;
  endsequence
  sequence s_int_low;
    !int_n_out;
  endsequence

  property p_int_on_event;
    s_enabled_event |=> s_int_low;
  endproperty
  a_int_on_event: assert property (p_int_on_event) // [R15]
    else $error("enabled event did not drive interrupt low");

  property p_int_tracks_cause;
    (|s_reg.cause) != int_n_out;
  endproperty
  a_int_tracks_cause: assert property (p_int_tracks_cause) // [R20]
    else $error("interrupt level disagrees with held causes");

  property p_cause_set;
    s_enabled_event |=> (s_reg.cause & $past(evt_en)) == $past(evt_en);
  endproperty
  a_cause_set: assert property (p_cause_set) // [R16] [R17]
    else $error("cause bit missing after enabled event");

  property p_cause_sticky;
    !(wr_in && reg_ofs == mas_pkg::OFS_CAUSE) && s_reg.cause != '0
    |=> (s_reg.cause & $past(s_reg.cause)) == $past(s_reg.cause);
  endproperty
  a_cause_sticky: assert property (p_cause_sticky) // [R20]
    else $error("cause bit dropped without a clear");

  property p_cause_clear;
    wr_in && acc_ok && reg_ofs == mas_pkg::OFS_CAUSE && acc_axis == 2'h0 &&
    wdata_in[mas_pkg::EVT_LSB+:EVTS] == '1 && evt_en[0] == '0
    |=> s_reg.cause[0] == '0;
  endproperty
  a_cause_clear: assert property (p_cause_clear) // [R20]
    else $error("cause clear of axis X did not take");

  property p_sync_with_int;
    s_reg.env5[0][mas_pkg::SYO_LSB+:4] == mas_pkg::TIM_CMP_FIRST &&
    s_reg.irq[0][mas_pkg::EVT_LSB+4] && cmp_hit_in[0]
    |=> sync_out[0] && !int_n_out;
  endproperty
  a_sync_with_int: assert property (p_sync_with_int) // [R18]
    else $error("interrupt not aligned with sync pulse");

  property p_ramp_enable;
    s_reg.irq[0][mas_pkg::EVT_LSB] && ramp_evt_in[0]
    |=> s_reg.cause[0][0] ##1 s_reg.cause[0][0] || $past(wr_in);
  endproperty
  a_ramp_enable: assert property (p_ramp_enable) // [R13]
    else $error("acceleration start cause not held");

  property p_cmp_disabled;
    s_reg.cause == '0 && evt_en == '0 |=> int_n_out;
  endproperty
  a_cmp_disabled: assert property (p_cmp_disabled) // [R14]
    else $error("interrupt raised with no enabled event");

  property p_status_read;
    rd_in && acc_ok && reg_ofs == mas_pkg::OFS_STAT
    |=> rdata_out == {28'h000_0000, $past(cond[acc_axis])};
  endproperty
  a_status_read: assert property (p_status_read) // [R12]
    else $error("status read returned wrong condition");

  property p_read_one_cycle;
    !rd_in |=> rdata_out == mas_pkg::REG_RESET;
  endproperty
  a_read_one_cycle: assert property (p_read_one_cycle)
    else $error("read data present without a read");

  property p_sync_one_cycle;
    sync_out[1] && cmp_hit_in[CMPS+:CMPS] == '0 &&
    ramp_evt_in[RAMPS+:RAMPS] == '0
    |=> !sync_out[1];
  endproperty
  a_sync_one_cycle: assert property (p_sync_one_cycle) // [R19]
    else $error("sync pulse longer than one cycle");

endmodule
